//--- rtl/bmwrc_regs.vh
// Register offsets, field positions, reset values and timing constants of the mode controller.
`ifndef BMWRC_REGS_VH
`define BMWRC_REGS_VH

// Register byte offsets on the APB.
`define BMWRC_OFS_CTRL        8'h00
`define BMWRC_OFS_FLAGS       8'h04
`define BMWRC_OFS_STATUS      8'h08
`define BMWRC_OFS_DISPLAY     8'h0C

// Control register fields.
`define BMWRC_CTRL_SLEEP_BIT  0
`define BMWRC_CTRL_DISP_BIT   1
`define BMWRC_CTRL_ARM_BIT    2
`define BMWRC_CTRL_RES_BIT    3
`define BMWRC_CTRL_PRD_LSB    4
`define BMWRC_CTRL_PRD_MSB    6

// Flag register fields (write one to clear).
`define BMWRC_FLAG_LSB        4
`define BMWRC_FLAG_MSB        7

// Reset values.
`define BMWRC_RST_PRD         3'h0
`define BMWRC_RST_RES         1'h0
`define BMWRC_RST_SEG         16'h0000
`define BMWRC_RST_FLAGS       4'h0

// Clock rates.
`define BMWRC_CLK_HZ          20000000
`define BMWRC_RTC_HZ          32768
`define BMWRC_RTC_DIV         (`BMWRC_CLK_HZ / `BMWRC_RTC_HZ)

// Debounce clock: crystal divided by 1024.
`define BMWRC_DB_DIV_BITS     10

// Timing in crystal cycles and in milliseconds.
`define BMWRC_RESET_RTC_CYC   24'h001004
`define BMWRC_NOPWR_RTC_CYC   24'h000002
`define BMWRC_PWR_RTC_CYC     24'h001004
`define BMWRC_WT_SHORT_MS     2500
`define BMWRC_WT_LONG_MS      60000
`define BMWRC_WT_SHORT_TICKS  (`BMWRC_WT_SHORT_MS * `BMWRC_RTC_HZ / 1000)
`define BMWRC_WT_LONG_TICKS   (`BMWRC_WT_LONG_MS * `BMWRC_RTC_HZ / 1000)

`endif

//--- rtl/bmwrc_mode_ctrl.v
// Battery mode, wake and reset controller with its APB register slave.
`timescale 1ns/100ps
`include "bmwrc_regs.vh"

// Function
// RULE_01 - Display-only mode keeps MPU off while segment registers drive blinking pins.
// RULE_02 - Display-only mode ends only on power return, timer expiry or button.
// RULE_03 - Deep sleep keeps only oscillator and RTC; same three exits.
// RULE_04 - Reset pin high halts logic except RTC and clears all configuration.
// RULE_05 - With power, reset lasts 4100 RTC cycles, then run-enable rises, boot.
// RULE_06 - Without power, reset lasts 2 crystal cycles, then battery-active mode.
// RULE_07 - Power fault clears PLL-locked and enters battery-active mode if battery present.
// RULE_08 - After power returns, MPU held in reset 4100 cycles, then full power.
// RULE_09 - Power fault with no battery margin drops run-enable and enters deep sleep.
// RULE_10 - Battery-active to full power on PLL lock, flag raised, configuration kept.
// RULE_11 - Display-only or sleep to full power with configuration at reset values.
// RULE_12 - Watchdog becomes active whenever full-power mode is entered.
// RULE_13 - Button edge in low modes raises run-enable and button flag promptly.
// RULE_14 - Button debounced by a 32 Hz state machine rejecting short noise.
// RULE_15 - After a detected edge, button ignored until the MPU clears its flag.
// RULE_16 - Wake timer expiry in low modes raises run-enable and timer flag.
// RULE_17 - Timer counts in low modes; LSB one minute or 2.5 s, 1-7 LSBs.
// RULE_18 - Arm bit presets timer; it starts only on a low-mode request.
// RULE_19 - Software arms the timer at least three RTC cycles before requesting.
// RULE_20 - Timer reset and disarmed when the MPU wakes; software re-arms it.
// RULE_21 - Battery-active request bit enters its mode at once; only one acts.
// RULE_22 - Power-loss flag at bit 7, power-return flag at bit 6.
// RULE_23 - Sleep forced by low margin persists even when margin recovers.
// RULE_24 - Debounce clock is the crystal divided by 1024, running in every mode.
module bmwrc_mode_ctrl #(
  parameter [23:0] RESET_TICKS    = `BMWRC_RESET_RTC_CYC,
  parameter [23:0] PWR_TICKS      = `BMWRC_PWR_RTC_CYC,
  parameter [23:0] WT_SHORT_TICKS = `BMWRC_WT_SHORT_TICKS,
  parameter [23:0] WT_LONG_TICKS  = `BMWRC_WT_LONG_TICKS
) (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        arst_n_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // Pins from outside
  input  wire        reset_pin_in,
  input  wire        power_good_in,
  input  wire        battery_margin_ok_in,
  input  wire        pushbutton_input_in,
  // Mode outputs
  output reg  [2:0]  mode_out,
  output reg         run_enable_out,
  output reg         mpu_run_out,
  output reg         pll_locked_out,
  output reg         watchdog_enable_out,
  output reg  [7:0]  segment_drive_out
);

  localparam [2:0] MODE_RESET    = 3'h0;
  localparam [2:0] MODE_MISSION  = 3'h1;
  localparam [2:0] MODE_BROWNOUT = 3'h2;
  localparam [2:0] MODE_DISPLAY  = 3'h3;
  localparam [2:0] MODE_SLEEP    = 3'h4;
  localparam [2:0] MODE_PWAIT    = 3'h5;

  localparam [1:0] DB_LOW      = 2'h0;
  localparam [1:0] DB_ONE      = 2'h1;
  localparam [1:0] DB_HELD     = 2'h2;
  localparam [1:0] DB_WAIT_LOW = 2'h3;

  localparam       RTC_DIV_FULL = (`BMWRC_RTC_DIV) - 1;
  localparam [9:0] RTC_DIV_M1   = RTC_DIV_FULL[9:0];
  localparam [9:0] DB_WRAP    = {`BMWRC_DB_DIV_BITS{1'b1}};

  reg        rst_s1_ff, rst_n_ff, rtc_tick_ff, from_low_ff;
  reg        run_en_ff, mpu_run_ff, pll_ff, wdt_ff, res_ff, armed_ff;
  reg [3:0]  sync1_ff, sync2_ff, flags_ff;
  reg [9:0]  rtc_div_ff;
  reg [14:0] rtc_pre_ff;
  reg [2:0]  mode_ff, prev_mode_ff, prd_ff;
  reg [23:0] wait_ff, wt_cnt_ff;
  reg [15:0] seg_ff;
  reg [1:0]  db_ff;

  wire pin_high = sync2_ff[0];
  wire pwr_ok   = sync2_ff[1];
  wire battery_margin_ok   = sync2_ff[2];
  wire pb_level = sync2_ff[3];

  wire acc      = psel_in & penable_in;
  wire commit   = acc & pready_out;
  wire wr_en    = commit & pwrite_in & ~pin_high;
  wire ctrl_wr  = wr_en && (paddr_in == `BMWRC_OFS_CTRL);
  wire flag_wr  = wr_en && (paddr_in == `BMWRC_OFS_FLAGS);
  wire seg_wr   = wr_en && (paddr_in == `BMWRC_OFS_DISPLAY);
  wire req_slp  = ctrl_wr & pwdata_in[`BMWRC_CTRL_SLEEP_BIT];
  wire req_disp = ctrl_wr & pwdata_in[`BMWRC_CTRL_DISP_BIT];
  wire arm_set  = ctrl_wr & pwdata_in[`BMWRC_CTRL_ARM_BIT];
  wire [3:0] flag_clr = flag_wr ? pwdata_in[`BMWRC_FLAG_MSB:`BMWRC_FLAG_LSB] : 4'h0;

  wire tick32   = rtc_tick_ff && (rtc_pre_ff[9:0] == DB_WRAP);
  wire pb_det   = tick32 && (db_ff == DB_ONE) && pb_level;
  wire low_mode = (mode_ff == MODE_DISPLAY) || (mode_ff == MODE_SLEEP);
  wire wt_run   = armed_ff & low_mode;
  wire wt_exp   = wt_run && rtc_tick_ff && (wt_cnt_ff == 24'h000001);
  wire [23:0] rst_target = pwr_ok ? RESET_TICKS : `BMWRC_NOPWR_RTC_CYC;

  function [23:0] wt_preset;
    input       res;
    input [2:0] prd;
    reg   [47:0] prod;
    begin
      prod = {21'h000000, prd} * (res ? WT_LONG_TICKS : WT_SHORT_TICKS);
      wt_preset = prod[23:0];
    end
  endfunction

  // Reset release and pin synchronisers.
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {pushbutton_input_in, battery_margin_ok_in, power_good_in, reset_pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Crystal-rate tick and RTC prescaler; the reset pin does not stop them.
  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rtc_div_ff  <= 10'h000;
      rtc_tick_ff <= 1'b0;
      rtc_pre_ff  <= 15'h0000;
    end else begin
      rtc_tick_ff <= (rtc_div_ff == RTC_DIV_M1);
      if (rtc_div_ff == RTC_DIV_M1) begin
        rtc_div_ff <= 10'h000;
      end else begin
        rtc_div_ff <= rtc_div_ff + 10'h001;
      end
      if (rtc_tick_ff) begin
        rtc_pre_ff <= rtc_pre_ff + 15'h0001; // RULE_24
      end
    end
  end

  // Button debouncer: two consecutive high samples at 32 Hz make an edge.
  // A glitch shorter than one sample interval can never be seen twice.
  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      db_ff <= DB_WAIT_LOW;
    end else if (pin_high) begin
      db_ff <= DB_WAIT_LOW;
    end else begin
      case (db_ff)
        DB_LOW: begin
          if (tick32 && pb_level) begin
            db_ff <= DB_ONE; // RULE_14
          end
        end
        DB_ONE: begin
          if (tick32) begin
            db_ff <= pb_level ? DB_HELD : DB_LOW; // RULE_14
          end
        end
        DB_HELD: begin
          if (!flags_ff[0]) begin
            db_ff <= DB_WAIT_LOW; // RULE_15
          end
        end
        default: begin
          if (tick32 && !pb_level) begin
            db_ff <= DB_LOW;
          end
        end
      endcase
    end
  end

  // Mode sequencer, configuration registers and wake timer.
  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      {mode_ff, prev_mode_ff, from_low_ff, wait_ff} <= {MODE_RESET, MODE_RESET, 25'h0000000};
      {run_en_ff, mpu_run_ff, pll_ff, wdt_ff, armed_ff} <= 5'h00;
      {res_ff, prd_ff, wt_cnt_ff} <= {`BMWRC_RST_RES, `BMWRC_RST_PRD, 24'h000000};
      {seg_ff, flags_ff} <= {`BMWRC_RST_SEG, `BMWRC_RST_FLAGS};
    end else if (pin_high) begin
      {mode_ff, prev_mode_ff, from_low_ff, wait_ff} <= {MODE_RESET, MODE_RESET, 25'h0000000};
      {run_en_ff, mpu_run_ff, pll_ff, wdt_ff, armed_ff} <= 5'h00;
      {res_ff, prd_ff, wt_cnt_ff} <= {`BMWRC_RST_RES, `BMWRC_RST_PRD, 24'h000000};
      {seg_ff, flags_ff} <= {`BMWRC_RST_SEG, `BMWRC_RST_FLAGS}; // RULE_04
    end else begin
      // Later assignments in this block set flags, so a set beats a clear.
      flags_ff <= flags_ff & ~flag_clr;
      if (ctrl_wr) begin
        res_ff <= pwdata_in[`BMWRC_CTRL_RES_BIT];
        prd_ff <= pwdata_in[`BMWRC_CTRL_PRD_MSB:`BMWRC_CTRL_PRD_LSB];
      end
      if (seg_wr) begin
        seg_ff <= pwdata_in[15:0];
      end
      if (arm_set) begin
        armed_ff  <= 1'b1; // RULE_18
        wt_cnt_ff <= wt_preset(pwdata_in[`BMWRC_CTRL_RES_BIT],
                               pwdata_in[`BMWRC_CTRL_PRD_MSB:`BMWRC_CTRL_PRD_LSB]);
      end else if (wt_run && rtc_tick_ff && (wt_cnt_ff != 24'h000000)) begin
        wt_cnt_ff <= wt_cnt_ff - 24'h000001; // RULE_17
      end

      case (mode_ff)
        MODE_RESET: begin
          if (rtc_tick_ff) begin
            if (wait_ff >= rst_target - 24'h000001) begin
              wait_ff    <= 24'h000000;
              {run_en_ff, mpu_run_ff, wdt_ff} <= 3'h7;
              if (pwr_ok) begin
                mode_ff <= MODE_MISSION; // RULE_05
                pll_ff  <= 1'b1;
              end else begin
                mode_ff <= MODE_BROWNOUT; // RULE_06
              end
            end else begin
              wait_ff <= wait_ff + 24'h000001;
            end
          end
        end
        MODE_MISSION: begin
          if (!pwr_ok) begin
            pll_ff      <= 1'b0; // RULE_07
            flags_ff[3] <= 1'b1; // RULE_22
            if (battery_margin_ok) begin
              mode_ff <= MODE_BROWNOUT; // RULE_07
            end else begin
              mode_ff    <= MODE_SLEEP; // RULE_09
              {run_en_ff, mpu_run_ff, wdt_ff} <= 3'h0;
            end
          end
        end
        MODE_BROWNOUT: begin
          if (pwr_ok) begin
            mode_ff      <= MODE_PWAIT;
            prev_mode_ff <= MODE_BROWNOUT;
            from_low_ff  <= 1'b0;
            wait_ff      <= 24'h000000;
            mpu_run_ff   <= 1'b0; // RULE_08
          end else if (!battery_margin_ok || req_slp || req_disp) begin
            // Sleep wins when both request bits arrive in one write.
            mode_ff    <= (!battery_margin_ok || req_slp) ? MODE_SLEEP : MODE_DISPLAY; // RULE_21 RULE_09
            {run_en_ff, mpu_run_ff, wdt_ff} <= 3'h0; // RULE_01
          end
        end
        MODE_DISPLAY, MODE_SLEEP: begin
          // Only these three events leave a low mode; margin recovery is not one.
          if (pwr_ok) begin
            mode_ff      <= MODE_PWAIT; // RULE_02 RULE_03 RULE_23
            prev_mode_ff <= mode_ff;
            from_low_ff  <= 1'b1;
            wait_ff      <= 24'h000000;
          end else if (pb_det || wt_exp) begin
            mode_ff    <= MODE_BROWNOUT; // RULE_02 RULE_03
            {run_en_ff, mpu_run_ff, wdt_ff} <= 3'h7; // RULE_13 RULE_16
            {armed_ff, wt_cnt_ff} <= 25'h0000000; // RULE_20
            {res_ff, prd_ff, seg_ff} <= {`BMWRC_RST_RES, `BMWRC_RST_PRD, `BMWRC_RST_SEG};
            if (pb_det) begin
              flags_ff[0] <= 1'b1; // RULE_13
            end
            if (wt_exp) begin
              flags_ff[1] <= 1'b1; // RULE_16
            end
          end
        end
        MODE_PWAIT: begin
          if (!pwr_ok) begin
            mode_ff    <= prev_mode_ff;
            mpu_run_ff <= (prev_mode_ff == MODE_BROWNOUT);
          end else if (rtc_tick_ff) begin
            if (wait_ff >= PWR_TICKS - 24'h000001) begin
              mode_ff     <= MODE_MISSION; // RULE_08 RULE_10 RULE_11
              pll_ff      <= 1'b1;
              flags_ff[2] <= 1'b1; // RULE_22
              {run_en_ff, mpu_run_ff, wdt_ff} <= 3'h7; // RULE_12
              {armed_ff, wt_cnt_ff} <= 25'h0000000; // RULE_20
              wait_ff     <= 24'h000000;
              if (from_low_ff) begin // RULE_11
                {res_ff, prd_ff, seg_ff} <= {`BMWRC_RST_RES, `BMWRC_RST_PRD, `BMWRC_RST_SEG};
              end
            end else begin
              wait_ff <= wait_ff + 24'h000001;
            end
          end
        end
        default: begin
          mode_ff <= MODE_RESET;
        end
      endcase
    end
  end

  // Registered outputs; segments blink at about 1 Hz from the prescaler.
  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      {mode_out, run_enable_out, mpu_run_out} <= {MODE_RESET, 2'h0};
      {pll_locked_out, watchdog_enable_out, segment_drive_out} <= 10'h000;
    end else begin
      mode_out            <= mode_ff;
      run_enable_out      <= run_en_ff;
      mpu_run_out         <= mpu_run_ff;
      pll_locked_out      <= pll_ff;
      watchdog_enable_out <= wdt_ff;
      if ((mode_ff == MODE_MISSION) || (mode_ff == MODE_BROWNOUT) ||
          (mode_ff == MODE_DISPLAY)) begin
        segment_drive_out <= seg_ff[7:0] & ~(seg_ff[15:8] & {8{rtc_pre_ff[14]}}); // RULE_01
      end else begin
        segment_drive_out <= 8'h00; // RULE_03
      end
    end
  end

  // APB slave: one wait state, data and error registered with pready.
  always @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out <= acc & ~pready_out;
      if (acc && !pready_out) begin
        pslverr_out <= 1'b0;
        prdata_out  <= 32'h00000000;
        if (paddr_in == `BMWRC_OFS_CTRL) begin
          prdata_out[`BMWRC_CTRL_ARM_BIT] <= armed_ff;
          prdata_out[`BMWRC_CTRL_RES_BIT] <= res_ff;
          prdata_out[`BMWRC_CTRL_PRD_MSB:`BMWRC_CTRL_PRD_LSB] <= prd_ff;
        end else if (paddr_in == `BMWRC_OFS_FLAGS) begin
          prdata_out[`BMWRC_FLAG_MSB:`BMWRC_FLAG_LSB] <= flags_ff;
        end else if (paddr_in == `BMWRC_OFS_STATUS) begin
          prdata_out[8:0] <= {pb_level, battery_margin_ok, pwr_ok, pll_ff, mpu_run_ff, run_en_ff,
                              mode_ff};
        end else if (paddr_in == `BMWRC_OFS_DISPLAY) begin
          prdata_out[15:0] <= seg_ff;
        end else begin
          pslverr_out <= 1'b1;
        end
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

endmodule

//--- tb/bmwrc_mode_ctrl_asserts.sv
// Concurrent checks on the ports of the mode controller.
`timescale 1ns/100ps
module bmwrc_mode_ctrl_chk #(
  parameter [23:0] PWR_TICKS = 24'h000004
) (
  // Clock, reset and bus
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       reset_pin_in,
  input wire logic       pready_out,
  input wire logic       pslverr_out,
  // Mode outputs
  input wire logic [2:0] mode_out,
  input wire logic       run_enable_out,
  input wire logic       mpu_run_out,
  input wire logic       pll_locked_out,
  input wire logic       watchdog_enable_out,
  input wire logic [7:0] segment_drive_out
);
  reg [23:0] wait_cnt_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Counts clocks spent waiting for power to settle, so the hold-off length can be judged.
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      wait_cnt_ff <= 24'h000000;
    else if (mode_out == 3'h5)
      wait_cnt_ff <= wait_cnt_ff + 24'h000001;
    else
      wait_cnt_ff <= 24'h000000;
  end

  a_pready_single: assert property (pready_out |=> !pready_out)
    else $error("pready stood longer than one cycle");
  a_pready_latency: assert property (psel_in && $rose(penable_in) |=> pready_out)
    else $error("pready did not follow the access phase");
  a_slverr_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_pin_holds_reset: assert property (reset_pin_in [*6] |-> mode_out == 3'h0 && !mpu_run_out)
    else $error("logic ran while the reset pin was high");
  a_full_power_wdog: assert property (mode_out == 3'h1 |-> watchdog_enable_out && pll_locked_out)
    else $error("full power without watchdog or lock");
  a_battery_no_pll: assert property (mode_out inside {3'h2, 3'h3, 3'h4} && $stable(mode_out)
    |-> !pll_locked_out)
    else $error("lock flag high on battery");
  a_low_mpu_off: assert property (mode_out inside {3'h3, 3'h4} && $stable(mode_out)
    |-> !mpu_run_out && !run_enable_out)
    else $error("processor enabled in a low mode");
  a_low_exit_paths: assert property ($past(mode_out) inside {3'h3, 3'h4}
    && !(mode_out inside {3'h3, 3'h4}) |-> mode_out inside {3'h0, 3'h2, 3'h5})
    else $error("low mode left by an illegal path");
  a_sleep_no_seg: assert property (mode_out inside {3'h0, 3'h4, 3'h5} && $stable(mode_out)
    |-> segment_drive_out == 8'h00)
    else $error("segments driven while asleep");
  a_return_wait_len: assert property ($past(mode_out) == 3'h5 && mode_out == 3'h1
    |-> $past(wait_cnt_ff) >= (PWR_TICKS - 24'h000001) * 24'h000262)
    else $error("power return hold-off too short");

  c_display: cover property (mode_out == 3'h3);
  c_sleep: cover property (mode_out == 3'h4);
  c_return: cover property ($past(mode_out) == 3'h5 && mode_out == 3'h1);
  c_slverr: cover property (pslverr_out);
endmodule

//--- tb/bmwrc_far_side.sv
// Model of the supply comparator, regulator margin, pushbutton and reset pin.
`timescale 1ns/100ps
module bmwrc_far_side #(
  parameter [7:0] FAULT_THRESHOLD = 8'h80
) (
  // Clock and levels chosen by the bench
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] supply_sense_input_in,
  input  wire logic       battery_up_in,
  input  wire logic       press_in,
  input  wire logic       pin_high_in,
  // Pins seen by the controller
  output logic            power_good_out,
  output logic            battery_margin_ok_out,
  output logic            pushbutton_input_out,
  output logic            reset_pin_out
);
  initial begin
    power_good_out = 1'b1;
    battery_margin_ok_out = 1'b1;
    pushbutton_input_out = 1'b0;
    reset_pin_out = 1'b0;
  end

  // The comparator output falls once the sensed supply drops below the threshold.
  always @(posedge ref_clk_in) begin
    power_good_out <= (supply_sense_input_in >= FAULT_THRESHOLD);
    battery_margin_ok_out <= battery_up_in;
    pushbutton_input_out <= press_in;
    reset_pin_out <= pin_high_in;
  end
endmodule

//--- tb/tb_battery_mode_wake_reset_ctrl.sv
// Self-checking bench for the battery mode, wake and reset controller.
`timescale 1ns/100ps
`include "bmwrc_regs.vh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_battery_mode_wake_reset_ctrl;
  localparam int TICK  = 610;
  localparam int SHORT = 3;
  localparam int LONG  = 5;
  logic        ref_clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in, supply, segment_drive_out;
  logic [31:0] pwdata_in, prdata_out, rd, seg;
  logic        reset_pin_in, power_good_in, battery_margin_ok_in, pushbutton_input_in;
  logic        batt, press, pin, err, run_enable_out, mpu_run_out;
  logic        pll_locked_out, watchdog_enable_out;
  logic [2:0]  mode_out, prd;
  int          n_errors, n_compared;

  bmwrc_mode_ctrl #(.RESET_TICKS(24'h000004), .PWR_TICKS(24'h000004),
    .WT_SHORT_TICKS(SHORT), .WT_LONG_TICKS(LONG)) dut (.ref_clk_in, .arst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .reset_pin_in, .power_good_in, .battery_margin_ok_in, .pushbutton_input_in, .mode_out,
    .run_enable_out, .mpu_run_out, .pll_locked_out, .watchdog_enable_out, .segment_drive_out);

  bmwrc_far_side u_far (.ref_clk_in(ref_clk_in), .supply_sense_input_in(supply),
    .battery_up_in(batt), .press_in(press), .pin_high_in(pin),
    .power_good_out(power_good_in), .battery_margin_ok_out(battery_margin_ok_in),
    .pushbutton_input_out(pushbutton_input_in), .reset_pin_out(reset_pin_in));

  function automatic logic [31:0] ctrl_word(input logic [1:0] req, input logic arm,
                                            input logic res, input logic [2:0] p);
    return {25'h0000000, p, res, arm, req};
  endfunction

  function automatic int wake_cycles(input logic res, input logic [2:0] p);
    return p * (res ? LONG : SHORT) * TICK;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk_in);
        k++;
      end while (pready_out !== 1'b1 && k < 20);
      if (k >= 20) n_errors++;
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic wait_mode(input logic [2:0] m, input int lim);
    int k;
    begin
      k = 0;
      while (mode_out !== m && k < lim) begin
        @(posedge ref_clk_in);
        k++;
      end
      `CHK("mode", m, mode_out)
    end
  endtask

  task summarize;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // The slowest scenarios span a few dozen crystal ticks; this leaves ample margin.
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_errors++;
    summarize;
  end

  initial begin
    {arst_n_in, psel_in, penable_in, pwrite_in, press, pin} = 6'h00;
    paddr_in = 8'h00;
    pwdata_in = 32'h00000000;
    supply = 8'hC0;
    batt = 1'b1;
    n_errors = 0;
    n_compared = 0;
    seg = $urandom(67);
    repeat (16) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    cycles(3 * TICK - 20);
    `CHK("boot", 3'h0, mode_out)
    wait_mode(3'h1, 2 * TICK);
    `CHK("wdog", 1'b1, watchdog_enable_out)
    apb(1'b0, `BMWRC_OFS_CTRL, 32'h0);
    `CHK("ctrl rst", 32'h0, rd & 32'h7C)
    seg = $urandom & 32'hFFFF;
    apb(1'b1, `BMWRC_OFS_DISPLAY, seg);
    apb(1'b0, `BMWRC_OFS_DISPLAY, 32'h0);
    `CHK("display", seg, rd & 32'hFFFF)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, err)
    supply <= $urandom % 8'h80;
    wait_mode(3'h2, 100);
    `CHK("pll", 1'b0, pll_locked_out)
    apb(1'b0, `BMWRC_OFS_FLAGS, 32'h0);
    `CHK("loss flag", 1'b1, rd[7])
    apb(1'b1, `BMWRC_OFS_FLAGS, 32'h80);
    apb(1'b0, `BMWRC_OFS_FLAGS, 32'h0);
    `CHK("loss clr", 1'b0, rd[7])
    supply <= 8'hC0;
    wait_mode(3'h5, 100);
    wait_mode(3'h1, 5 * TICK);
    apb(1'b0, `BMWRC_OFS_DISPLAY, 32'h0);
    `CHK("cfg kept", seg, rd & 32'hFFFF)
    apb(1'b1, `BMWRC_OFS_FLAGS, 32'h40);
    supply <= 8'h10;
    wait_mode(3'h2, 100);
    for (int i = 0; i < 2; i++) begin
      prd = 3'h1 + $urandom % 2;
      apb(1'b1, `BMWRC_OFS_CTRL, ctrl_word(2'h0, 1'b1, i[0], prd));
      apb(1'b0, `BMWRC_OFS_CTRL, 32'h0);
      `CHK("armed", 1'b1, rd[2])
      cycles(3 * TICK);
      apb(1'b1, `BMWRC_OFS_CTRL, ctrl_word(i ? 2'h1 : 2'h2, 1'b0, i[0], prd));
      wait_mode(i ? 3'h4 : 3'h3, 20);
      `CHK("run low", 1'b0, run_enable_out)
      cycles(wake_cycles(i[0], prd) - 2 * TICK);
      `CHK("early", i ? 3'h4 : 3'h3, mode_out)
      wait_mode(3'h2, 3 * TICK);
      cycles(2);
      `CHK("run high", 1'b1, run_enable_out)
      apb(1'b0, `BMWRC_OFS_FLAGS, 32'h0);
      `CHK("wake flag", 1'b1, rd[5])
      apb(1'b1, `BMWRC_OFS_FLAGS, 32'h20);
      apb(1'b0, `BMWRC_OFS_CTRL, 32'h0);
      `CHK("disarmed", 1'b0, rd[2])
    end
    apb(1'b0, `BMWRC_OFS_DISPLAY, 32'h0);
    `CHK("cfg clr", 32'h0, rd & 32'hFFFF)
    apb(1'b1, `BMWRC_OFS_CTRL, 32'h1);
    wait_mode(3'h4, 20);
    press <= 1'b1;
    cycles(200);
    press <= 1'b0;
    cycles(4 * TICK);
    `CHK("noise", 3'h4, mode_out)
    supply <= 8'hC0;
    wait_mode(3'h5, 100);
    wait_mode(3'h1, 5 * TICK);
    apb(1'b0, `BMWRC_OFS_FLAGS, 32'h0);
    `CHK("return flag", 1'b1, rd[6])
    batt <= 1'b0;
    supply <= 8'h20;
    wait_mode(3'h4, 100);
    `CHK("run off", 1'b0, run_enable_out)
    batt <= 1'b1;
    cycles(TICK);
    `CHK("sticky", 3'h4, mode_out)
    supply <= 8'hC0;
    wait_mode(3'h1, 6 * TICK);
    apb(1'b1, `BMWRC_OFS_DISPLAY, 32'h00FF);
    pin <= 1'b1;
    cycles(20);
    `CHK("pin", 3'h0, mode_out)
    apb(1'b0, `BMWRC_OFS_DISPLAY, 32'h0);
    `CHK("pin cfg", 32'h0, rd & 32'hFFFF)
    pin <= 1'b0;
    cycles(3 * TICK - 20);
    `CHK("pin boot", 3'h0, mode_out)
    wait_mode(3'h1, 2 * TICK);
    supply <= 8'h30;
    wait_mode(3'h2, 100);
    pin <= 1'b1;
    cycles(20);
    pin <= 1'b0;
    wait_mode(3'h2, 3 * TICK);
    summarize;
  end
endmodule

bind bmwrc_mode_ctrl bmwrc_mode_ctrl_chk #(.PWR_TICKS(PWR_TICKS)) u_chk (.ref_clk_in,
  .arst_n_in, .psel_in, .penable_in, .reset_pin_in, .pready_out, .pslverr_out, .mode_out,
  .run_enable_out, .mpu_run_out, .pll_locked_out, .watchdog_enable_out, .segment_drive_out);
